/* core/tsc_params.svh */
// constants of the time synchronisation controller
`ifndef TSC_PARAMS_SVH
`define TSC_PARAMS_SVH
`define TSC_CLK_PERIOD_NS  50
`define TSC_SECOND_NS      1000000000
`define TSC_TICKS_PER_SEC  (`TSC_SECOND_NS / `TSC_CLK_PERIOD_NS)
`define TSC_MODE_INTERNAL  3'h1
`define TSC_MODE_SCADA     3'h2
`define TSC_MODE_FIELDBUS  3'h3
`define TSC_MODE_IRIG      3'h4
`define TSC_MODE_RADIO     3'h5
`define TSC_MODE_BOX       3'h6
`define TSC_MODE_PULSE     3'h7
`define TSC_MODE_DEFAULT   3'h1
`define TSC_IRIG_MIN_YEAR  7'h5b
`define TSC_PULSE_ROUND    6'h1e
`define TSC_SEC_PER_MIN    60
`define TSC_MIN_PER_HOUR   60
`define TSC_MIN_PER_DAY    1440
`define TSC_OFFSET_MAX     1439
`define TSC_TOL_RESET      8'h02
`define TSC_SEP_EU         8'h2e
`define TSC_SEP_US         8'h2f
`endif

/* core/tsc_pkg.sv */
// types of the time synchronisation controller
package tsc_pkg;
	typedef struct packed {
		logic [6:0] year;
		logic [3:0] mon;
		logic [4:0] day;
		logic [4:0] hour;
		logic [5:0] min;
		logic [5:0] sec;
	} tsc_time_t;

	typedef enum logic [2:0] {
		J_IDLE = 3'b001,
		J_OFF  = 3'b010,
		J_YEAR = 3'b100
	} tsc_jump_t;

	typedef struct packed {
		tsc_time_t         t;
		tsc_time_t         stamp;
		logic [31:0]       presc;
		logic [15:0]       lost;
		logic [2:0]        mode;
		logic signed [11:0] off;
		logic signed [11:0] off_new;
		logic [6:0]        year;
		logic              pulse;
		logic              synced;
		logic              fault;
		logic              jon;
		logic              joff;
		tsc_jump_t         js;
		logic [4:0]        df1;
		logic [4:0]        df2;
		logic [7:0]        sep;
	} tsc_state_t;
endpackage : tsc_pkg

/* core/tsc_top.sv */
// time synchronisation controller: clock, source select, offset, supervision
`timescale 1ns/1ps
`include "tsc_params.svh"

// How it works
// - seven source modes, internal clock default
// - power-up or supply loss uses backed clock
// - sync only from chosen source, else freerun
// - radio time used only once decoded
// - irig year from setting, floor 91
// - pulse edge rounds to minute boundary
// - every pulse applied, never supervised
// - signed offset clamped to 1439 minutes
// - fault alarm after tolerance without sync
// - mode change breaks sync, resyncs next
// - synced offset change (irig/radio/box) or irig year change: jump start, jump end
// - jump start on loss, mode change, jump
// - jump end on strobe resync or after jump
// - date order and separator by format
module tsc_top
	import tsc_pkg::*;
#(
	parameter int TICKS = `TSC_TICKS_PER_SEC
) (
	// clock and reset
	input  wire logic              i_clock,
	input  wire logic              i_rst_n,
	// configuration
	input  wire logic [2:0]        i_mode,
	input  wire logic signed [11:0] i_offset_min,
	input  wire logic [6:0]        i_irig_year,
	input  wire logic [7:0]        i_tol_min,
	input  wire logic              i_date_us,
	// sources
	input  wire logic              i_power_good,
	input  wire logic [6:0]        i_sync_stb,
	input  wire tsc_time_t         i_rx_time,
	input  wire logic              i_radio_decoded,
	input  wire logic              i_bin_pulse,
	// time and status
	output tsc_time_t              o_time,
	output logic                   o_synced,
	output logic                   o_sync_fault,
	// jump messages
	output logic                   o_jump_on,
	output logic                   o_jump_off,
	output tsc_time_t              o_stamp,
	// formatted date
	output logic [4:0]             o_date_first,
	output logic [4:0]             o_date_second,
	output logic [7:0]             o_date_sep
);

	// **********************************************************************
	// calendar helpers
	// **********************************************************************

	// days in the month, leap year every fourth year
	function automatic logic [4:0] dim(input logic [3:0] m, input logic [6:0] y);
		case (m)
			4'h2:                      dim = (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
			4'h4, 4'h6, 4'h9, 4'hb:    dim = 5'h1e;
			default:                   dim = 5'h1f;
		endcase
	endfunction : dim

	// one day forward
	function automatic tsc_time_t next_day(input tsc_time_t t);
		tsc_time_t r;
		r = t;
		if (t.day >= dim(t.mon, t.year)) begin
			r.day = 5'h01;
			if (t.mon >= 4'hc) begin
				r.mon  = 4'h1;
				r.year = (t.year >= 7'h63) ? 7'h00 : t.year + 7'h01;
			end else begin
				r.mon = t.mon + 4'h1;
			end
		end else begin
			r.day = t.day + 5'h01;
		end
		return r;
	endfunction : next_day

	// one day back
	function automatic tsc_time_t prev_day(input tsc_time_t t);
		tsc_time_t r;
		r = t;
		if (t.day <= 5'h01) begin
			if (t.mon <= 4'h1) begin
				r.mon  = 4'hc;
				r.year = (t.year == 7'h00) ? 7'h63 : t.year - 7'h01;
			end else begin
				r.mon = t.mon - 4'h1;
			end
			r.day = dim(r.mon, r.year);
		end else begin
			r.day = t.day - 5'h01;
		end
		return r;
	endfunction : prev_day

	// add signed minutes, one day of carry at most
	function automatic tsc_time_t add_min(input tsc_time_t t, input logic signed [12:0] d);
		tsc_time_t r;
		int        m;
		r = t;
		m = int'(t.hour) * `TSC_MIN_PER_HOUR + int'(t.min) + int'(d);
		if (m < 0) begin
			m = m + `TSC_MIN_PER_DAY;
			r = prev_day(r);
		end else if (m >= `TSC_MIN_PER_DAY) begin
			m = m - `TSC_MIN_PER_DAY;
			r = next_day(r);
		end
		r.hour = 5'(m / `TSC_MIN_PER_HOUR);
		r.min  = 6'(m % `TSC_MIN_PER_HOUR);
		return r;
	endfunction : add_min

	// one second forward
	function automatic tsc_time_t tick(input tsc_time_t t);
		tsc_time_t r;
		r = t;
		if (t.sec >= 6'(`TSC_SEC_PER_MIN - 1)) begin
			r.sec = 6'h00;
			r = add_min(r, 13'sh0001);
		end else begin
			r.sec = t.sec + 6'h01;
		end
		return r;
	endfunction : tick

	// **********************************************************************
	// state
	// **********************************************************************

	tsc_state_t          s_q;
	tsc_state_t          s_d;
	logic signed [11:0]  off_clamp;
	logic [2:0]          eff_mode;
	logic [2:0]          src;
	logic                ext_mode;
	logic                sig_mode;
	logic                sync_evt;
	logic                pulse_edge;
	logic [6:0]          year_floor;

	// elaboration check of the prescaler
	if (TICKS < 2) begin : g_bad_ticks
		$error("TICKS must be at least 2");
	end

	// source selection and setting conditioning
	always_comb begin
		// offset held inside +-1439 minutes
		if (i_offset_min > 12'sd`TSC_OFFSET_MAX)
			off_clamp = 12'sd`TSC_OFFSET_MAX;
		else if (i_offset_min < -12'sd`TSC_OFFSET_MAX)
			off_clamp = -12'sd`TSC_OFFSET_MAX;
		else
			off_clamp = i_offset_min;
		// mode 0 is not legal and acts as internal
		eff_mode   = (s_q.mode == 3'h0) ? `TSC_MODE_INTERNAL : s_q.mode;
		// backed clock rules during power-up or supply loss
		src        = i_power_good ? eff_mode : `TSC_MODE_INTERNAL;
		ext_mode   = (src != `TSC_MODE_INTERNAL) && (src != `TSC_MODE_PULSE);
		sig_mode   = (src == `TSC_MODE_IRIG) || (src == `TSC_MODE_RADIO) ||
			(src == `TSC_MODE_BOX);
		// only the selected strobe counts, radio only once decoded
		sync_evt   = (src != `TSC_MODE_PULSE) && i_sync_stb[src - 3'h1] &&
			((src != `TSC_MODE_RADIO) || i_radio_decoded);
		pulse_edge = (src == `TSC_MODE_PULSE) && i_bin_pulse && !s_q.pulse;
		year_floor = (i_irig_year < `TSC_IRIG_MIN_YEAR) ? `TSC_IRIG_MIN_YEAR :
			i_irig_year;
	end

	// **********************************************************************
	// next state
	// **********************************************************************

	always_comb begin
		s_d       = s_q;
		s_d.jon   = 1'b0;
		s_d.joff  = 1'b0;
		s_d.pulse = i_bin_pulse;
		// free running seconds between syncs
		if (s_q.presc >= 32'(TICKS - 1)) begin
			s_d.presc = 32'h0;
			s_d.t     = tick(s_q.t);
			if (ext_mode && s_q.lost != 16'hffff)
				s_d.lost = s_q.lost + 16'h0001;
		end else begin
			s_d.presc = s_q.presc + 32'h1;
		end

		if (i_mode != s_q.mode) begin
			// new source: sync broken until it delivers
			s_d.mode   = i_mode;
			s_d.synced = 1'b0;
			s_d.lost   = 16'h0;
			s_d.jon    = 1'b1;
			s_d.stamp  = s_q.t;
			s_d.js     = J_IDLE;
		end else if (sync_evt) begin
			s_d.presc = 32'h0;
			s_d.js    = J_IDLE; // pending jump restarts from the synced time
			s_d.lost  = 16'h0;
			s_d.t     = i_rx_time;
			if (sig_mode)
				s_d.t = add_min(i_rx_time, 13'(s_q.off));
			if (src == `TSC_MODE_IRIG) begin
				s_d.t.year = s_q.year;
			end
			// resync after a break closes the jump
			if (!s_q.synced || s_q.fault) begin
				s_d.joff  = 1'b1;
				s_d.stamp = s_d.t;
			end
			s_d.synced = 1'b1;
			s_d.fault  = 1'b0;
		end else if (pulse_edge) begin
			// every edge applied, rounded to a whole minute
			s_d.presc = 32'h0;
			s_d.t.sec = 6'h00;
			if (s_q.t.sec > `TSC_PULSE_ROUND) begin
				s_d.t = add_min(s_d.t, 13'sh0001);
			end
			s_d.synced = 1'b1;
			s_d.fault  = 1'b0;
		end else begin
			case (s_q.js)
				J_IDLE: begin
					if (off_clamp != s_q.off) begin
						if (s_q.synced && sig_mode) begin
							// stamp without the offset first
							s_d.t       = add_min(s_q.t, -13'(s_q.off));
							s_d.stamp   = s_d.t;
							s_d.jon     = 1'b1;
							s_d.off_new = off_clamp;
							s_d.js      = J_OFF;
						end else begin
							s_d.off = off_clamp;
						end
					end else if (year_floor != s_q.year) begin
						if (s_q.synced && src == `TSC_MODE_IRIG) begin
							s_d.stamp = s_q.t;
							s_d.jon   = 1'b1;
							s_d.js    = J_YEAR;
						end else begin
							s_d.year = year_floor;
						end
					end else if (ext_mode && !s_q.fault &&
						s_q.lost > 16'(int'(i_tol_min) * `TSC_SEC_PER_MIN)) begin
						// cyclic sync missing beyond tolerance
						s_d.fault  = 1'b1;
						s_d.synced = 1'b0;
						s_d.jon    = 1'b1;
						s_d.stamp  = s_q.t;
					end
				end
				J_OFF: begin
					// jump applied with the new offset
					s_d.t     = add_min(s_d.t, 13'(s_q.off_new));
					s_d.off   = s_q.off_new;
					s_d.stamp = s_d.t;
					s_d.joff  = 1'b1;
					s_d.js    = J_IDLE;
				end
				J_YEAR: begin
					s_d.t.year = year_floor;
					s_d.year   = year_floor;
					s_d.stamp  = s_d.t;
					s_d.stamp.year = year_floor;
					s_d.joff   = 1'b1;
					s_d.js     = J_IDLE;
				end
				default: s_d.js = J_IDLE;
			endcase
		end

		// date presentation
		s_d.df1 = i_date_us ? 5'(s_d.t.mon) : s_d.t.day;
		s_d.df2 = i_date_us ? s_d.t.day : 5'(s_d.t.mon);
		s_d.sep = i_date_us ? `TSC_SEP_US : `TSC_SEP_EU;
	end

	// state register, synchronous reset to internal mode
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			s_q         <= '0;
			s_q.t.mon   <= 4'h1;
			s_q.t.day   <= 5'h01;
			s_q.stamp.mon <= 4'h1;
			s_q.stamp.day <= 5'h01;
			s_q.mode    <= `TSC_MODE_DEFAULT;
			s_q.year    <= `TSC_IRIG_MIN_YEAR;
			s_q.js      <= J_IDLE;
			s_q.df1     <= 5'h01;
			s_q.df2     <= 5'h01;
			s_q.sep     <= `TSC_SEP_EU;
		end else begin
			s_q <= s_d;
		end
	end

	// **********************************************************************
	// outputs
	// **********************************************************************

	assign o_time        = s_q.t;
	assign o_synced      = s_q.synced;
	assign o_sync_fault  = s_q.fault;
	assign o_jump_on     = s_q.jon;
	assign o_jump_off    = s_q.joff;
	assign o_stamp       = s_q.stamp;
	assign o_date_first  = s_q.df1;
	assign o_date_second = s_q.df2;
	assign o_date_sep    = s_q.sep;

endmodule : tsc_top

/* test/tsc_src_model.sv */
// model of the external time sources
`timescale 1ns/1ps
module tsc_src_model
	import tsc_pkg::*;
(
	// clock
	input  wire logic i_clock,
	// source lines
	output logic [6:0] o_stb,
	output tsc_time_t  o_rx,
	output logic       o_dec,
	output logic       o_pulse
);
	// idle lines at time zero
	initial begin
		o_stb = 7'h00;
		o_rx = '0;
		o_dec = 1'b0;
		o_pulse = 1'b0;
	end
	// one-cycle strobe of source k with its time
	task automatic send(input int k, input tsc_time_t t);
		@(posedge i_clock) o_stb <= 7'h01 << k;
		o_rx <= t;
		@(posedge i_clock) o_stb <= 7'h00;
		o_rx <= ~t; // released lines do not keep the value
		#1;
	endtask : send
	// radio decode done or lost
	task automatic decode(input logic d);
		@(posedge i_clock) o_dec <= d;
	endtask : decode
	// minute pulse, one rising edge
	task automatic pulse();
		@(posedge i_clock) o_pulse <= 1'b1;
		@(posedge i_clock) o_pulse <= 1'b0;
		#1;
	endtask : pulse
endmodule : tsc_src_model

/* test/tsc_chk.sv */
// assertions on the ports of the time sync controller
`timescale 1ns/1ps
module tsc_chk
	import tsc_pkg::*;
(
	// clock, reset, settings
	input wire logic              i_clock,
	input wire logic              i_rst_n,
	input wire logic [2:0]        i_mode,
	input wire logic signed [11:0] i_offset_min,
	input wire logic              i_date_us,
	// sources
	input wire logic              i_power_good,
	input wire logic [6:0]        i_sync_stb,
	input wire tsc_time_t         i_rx_time,
	input wire logic              i_radio_decoded,
	input wire logic              i_bin_pulse,
	// outputs
	input wire tsc_time_t         o_time,
	input wire logic              o_synced,
	input wire logic              o_sync_fault,
	input wire logic              o_jump_on,
	input wire logic              o_jump_off,
	input wire logic [4:0]        o_date_first,
	input wire logic [7:0]        o_date_sep
);
	logic up_q;
	// previous edge was out of reset
	always_ff @(posedge i_clock) up_q <= i_rst_n;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	// stable source selection
	sequence s_same;
		up_q && $stable({i_mode, i_power_good}) && i_power_good;
	endsequence
	sequence s_jump;
		o_jump_on ##1 o_jump_off;
	endsequence
	chk_sync_load: assert property (s_same and i_mode == 3'h2 && i_sync_stb == 7'h02
		|=> o_synced && o_time == $past(i_rx_time)) else $error("sync load wrong");
	chk_offset_jump: assert property (s_same and i_mode == 3'h4 && o_synced
		&& i_sync_stb == 7'h00 && $changed(i_offset_min) && !i_offset_min[11]
		&& i_offset_min < 12'sd1439 |=> s_jump) else $error("offset jump wrong");
	chk_pulse_round: assert property (s_same and i_mode == 3'h7 && $rose(i_bin_pulse)
		|=> o_time.sec == 6'h00) else $error("pulse rounding wrong");
	chk_radio_gate: assert property (i_mode == 3'h5 && !i_radio_decoded && !o_synced
		&& i_sync_stb == 7'h10 |=> !o_synced) else $error("undecoded radio used");
	chk_power_backed: assert property (!i_power_good && !i_sync_stb[0] && !o_synced
		|=> !o_synced) else $error("sync while supply low");
	chk_fault_rise: assert property ($rose(o_sync_fault) |-> !o_synced && o_jump_on)
		else $error("fault without jump start");
	chk_end_synced: assert property (o_jump_off |-> o_synced)
		else $error("jump end while unsynced");
	chk_date_sep: assert property (up_q |-> o_date_sep ==
		($past(i_date_us) ? 8'h2f : 8'h2e)) else $error("date separator wrong");
	chk_date_order: assert property (up_q && $past(i_date_us)
		|-> o_date_first == {1'b0, o_time.mon}) else $error("date order wrong");
	chk_sec_range: assert property (o_time.sec < 6'h3c)
		else $error("seconds out of range");
endmodule : tsc_chk
bind tsc_top tsc_chk u_chk (.i_clock, .i_rst_n, .i_mode, .i_offset_min, .i_date_us,
	.i_power_good, .i_sync_stb, .i_rx_time, .i_radio_decoded, .i_bin_pulse, .o_time,
	.o_synced, .o_sync_fault, .o_jump_on, .o_jump_off, .o_date_first, .o_date_sep);

/* test/tsc_top_bench.sv */
// self-checking bench of the time sync controller
`timescale 1ns/1ps
module tsc_top_bench;
	import tsc_pkg::*;
	// design inputs
	logic               i_clock = 1'b0;
	logic               i_rst_n = 1'b0;
	logic [2:0]         i_mode = 3'h1;
	logic signed [11:0] i_offset_min = 12'sh000;
	logic [6:0]         i_irig_year = 7'h32;
	logic [7:0]         i_tol_min = 8'h02;
	logic               i_date_us = 1'b0;
	logic               i_power_good = 1'b1;
	// outputs and source lines
	tsc_time_t          o_time, o_stamp, rx;
	tsc_time_t          t = {7'h18, 4'h3, 5'h09, 5'h05, 6'h0a, 6'h1f};
	logic               o_synced, o_sync_fault, o_jump_on, o_jump_off, dec, pul;
	logic [4:0]         o_date_first, o_date_second;
	logic [7:0]         o_date_sep;
	logic [6:0]         stb;
	logic [5:0]         sv [2] = '{6'h1f, 6'h1d};
	int                 num_errors = 0;
	int                 comparisons = 0;
	int                 n;
	always #25 i_clock = ~i_clock;
	tsc_top #(.TICKS(20)) dut (.i_clock, .i_rst_n, .i_mode, .i_offset_min, .i_irig_year,
		.i_tol_min, .i_date_us, .i_power_good, .i_sync_stb(stb), .i_rx_time(rx),
		.i_radio_decoded(dec), .i_bin_pulse(pul), .o_time, .o_synced, .o_sync_fault,
		.o_jump_on, .o_jump_off, .o_stamp, .o_date_first, .o_date_second, .o_date_sep);
	tsc_src_model src (.i_clock, .o_stb(stb), .o_rx(rx), .o_dec(dec), .o_pulse(pul));
	// ****************************************
	// compare and wait helpers
	// ****************************************
	task automatic cmp_t(input tsc_time_t got, input tsc_time_t exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_t
	task automatic cmp_b(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_b
	task automatic tick(input int k);
		repeat (k) @(posedge i_clock);
		#1;
	endtask : tick
	task automatic print_verdict();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	// hang guard
	initial begin
		#1ms;
		num_errors++;
		print_verdict();
	end
	// main sequence
	initial begin
		tick(20);
		@(posedge i_clock) i_rst_n <= 1'b1;
		tick(1);
		cmp_t(o_time, {7'h00, 4'h1, 5'h01, 5'h00, 6'h00, 6'h00});
		cmp_b(8'(o_synced), 8'h00);
		cmp_b(o_date_sep, 8'h2e);
		@(posedge i_clock) i_power_good <= 1'b0;
		i_mode <= 3'h2;
		src.send(1, t);
		cmp_b(8'(o_synced), 8'h00);
		@(posedge i_clock) i_power_good <= 1'b1;
		tick(2);
		src.send(1, t);
		cmp_t(o_time, t);
		cmp_b(8'({o_synced, o_jump_off}), 8'h03);
		src.send(2, {t[32:17], 17'h00000});
		cmp_b(8'(o_time.hour), 8'h05);
		cmp_b(8'(o_date_first), 8'h09);
		cmp_b(8'(o_date_second), 8'h03);
		@(posedge i_clock) i_date_us <= 1'b1;
		tick(2);
		cmp_b({o_date_first, o_date_sep[2:0]}, 8'h1f);
		cmp_b(8'(o_date_second), 8'h09);
		foreach (sv[i]) begin
			@(posedge i_clock) i_mode <= 3'h2;
			tick(2);
			src.send(1, {t[32:6], sv[i]});
			@(posedge i_clock) i_mode <= 3'h7;
			tick(1);
			cmp_b(8'(o_jump_on), 8'h01);
			src.pulse();
			cmp_t(o_time, {t[32:12], t[11:6] + {5'h00, sv[i] > 6'h1e}, 6'h00});
		end
		@(posedge i_clock) i_mode <= 3'h4;
		tick(2);
		src.send(3, t);
		cmp_t(o_time, {7'h5b, t[25:0]});
		@(posedge i_clock) i_offset_min <= 12'sh03c;
		tick(1);
		cmp_b(8'({o_jump_on, o_stamp.hour}), 8'h25);
		tick(1);
		cmp_b(8'({o_jump_off, o_synced, o_time.hour}), 8'h66);
		@(posedge i_clock) i_offset_min <= 12'sh7d0;
		tick(2);
		cmp_b(8'({o_jump_off, o_time.hour}), 8'h25);
		cmp_b({o_time.day, 3'h0}, 8'h50);
		cmp_b(8'(o_time.min), 8'h09);
		@(posedge i_clock) i_mode <= 3'h5;
		src.decode(1'b0);
		tick(2);
		src.send(4, t);
		cmp_b(8'(o_synced), 8'h00);
		src.decode(1'b1);
		src.send(4, t);
		cmp_b(8'({o_synced, o_jump_off}), 8'h03);
		@(posedge i_clock) i_mode <= 3'h2;
		tick(2);
		src.send(1, t);
		for (n = 0; n < 3000 && o_sync_fault !== 1'b1; n++)
			tick(1);
		if (n == 3000) begin
			num_errors++; // fault never came
		end else begin
			cmp_b(8'({o_sync_fault, o_synced}), 8'h02);
			cmp_b(8'(n > 2380 && n < 2450), 8'h01);
			cmp_t(o_time, {t[32:12], 6'h0c, 6'h20});
			src.send(1, t);
			cmp_b(8'({o_sync_fault, o_jump_off}), 8'h01);
		end
		print_verdict();
	end
endmodule : tsc_top_bench
